// ==== shared/cdtim_pkg.sv ====
package cdtim_pkg;
	// register port
	localparam int CDTIM_ADDR_W = 5;
	localparam int CDTIM_DATA_W = 32;
	localparam logic [4:0] CDTIM_CTRL_ADDR = 5'h00;
	localparam logic [4:0] CDTIM_ON_ADDR = 5'h04;
	localparam logic [4:0] CDTIM_OFF_ADDR = 5'h08;
	localparam logic [4:0] CDTIM_STAT_ADDR = 5'h0c;
	localparam logic [4:0] CDTIM_NOW_ADDR = 5'h10;
	// control bits
	localparam int CDTIM_CTRL_EN = 0;
	localparam int CDTIM_CTRL_YEARLY = 1;
	localparam int CDTIM_CTRL_MONTHLY = 2;
	localparam int CDTIM_CTRL_PULSE = 3;
	// status bits
	localparam int CDTIM_STAT_OUT = 0;
	localparam int CDTIM_STAT_RUN = 1;
	localparam int CDTIM_STAT_DONE = 2;
	localparam int CDTIM_STAT_ERR = 3;
	// date word layout
	localparam int CDTIM_DAY_LSB = 0;
	localparam int CDTIM_MON_LSB = 8;
	localparam int CDTIM_YEAR_LSB = 16;
	localparam int CDTIM_DC_DAY = 24;
	localparam int CDTIM_DC_MON = 25;
	localparam int CDTIM_DC_YEAR = 26;
	localparam int CDTIM_YEAR_W = 7;
	localparam int CDTIM_MON_W = 4;
	localparam int CDTIM_DAY_W = 5;
	localparam int CDTIM_KEY_W = CDTIM_YEAR_W + CDTIM_MON_W + CDTIM_DAY_W;
	// calendar limits; years are held as offsets from the base year
	localparam int CDTIM_YEAR_BASE = 2000;
	localparam int CDTIM_YEAR_LAST = 2099;
	localparam logic [6:0] CDTIM_YEAR_MAX = 7'(CDTIM_YEAR_LAST - CDTIM_YEAR_BASE);
	localparam logic [3:0] CDTIM_MON_MIN = 4'h1;
	localparam logic [3:0] CDTIM_MON_MAX = 4'hc;
	localparam logic [4:0] CDTIM_DAY_MIN = 5'h01;
	localparam logic [4:0] CDTIM_DAY_MAX = 5'h1f;
	// month 15 never occurs, so this key never equals a real date
	localparam logic [15:0] CDTIM_NO_DATE = 16'hffff;
	localparam logic [31:0] CDTIM_ZERO = 32'h0000_0000;

	typedef enum logic [2:0] {
		CDTIM_IDLE = 3'b001,
		CDTIM_RUN = 3'b010,
		CDTIM_DONE = 3'b100
	} cdtim_state_e;

	typedef struct packed {
		logic dc_year;
		logic dc_mon;
		logic dc_day;
		logic [6:0] year;
		logic [3:0] mon;
		logic [4:0] day;
	} cdtim_date_s;
endpackage : cdtim_pkg

// ==== hw/cdtim_timer.sv ====
`timescale 1ns/1ps
module cdtim_timer
	import cdtim_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [CDTIM_ADDR_W-1:0] reg_addr,
	input wire logic [CDTIM_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [CDTIM_DATA_W-1:0] reg_rdata,
	input wire logic [CDTIM_YEAR_W-1:0] rtc_year,
	input wire logic [CDTIM_MON_W-1:0] rtc_month,
	input wire logic [CDTIM_DAY_W-1:0] rtc_day,
	input wire logic scan_pulse,
	output logic timer_out
);

	typedef struct packed {
		cdtim_state_e fsm;
		logic en;
		logic yearly;
		logic monthly;
		logic pulse;
		cdtim_date_s on_date;
		cdtim_date_s off_date;
		logic [CDTIM_KEY_W-1:0] sync1;
		logic [CDTIM_KEY_W-1:0] sync2;
		logic [CDTIM_KEY_W-1:0] sync3;
		logic [CDTIM_KEY_W-1:0] cur_date;
		logic [CDTIM_KEY_W-1:0] last_eval;
		logic [CDTIM_KEY_W-1:0] last_pulse;
		logic cfg_new;
		logic cfg_err;
		logic out;
		logic [CDTIM_DATA_W-1:0] rdata;
	} cdtim_regs_s;

	cdtim_regs_s st_reg;
	cdtim_regs_s st_next;

	function automatic cdtim_date_s cdtim_unpack(input logic [CDTIM_DATA_W-1:0] w);
		cdtim_date_s d;
		d.dc_year = w[CDTIM_DC_YEAR];
		d.dc_mon = w[CDTIM_DC_MON];
		d.dc_day = w[CDTIM_DC_DAY];
		d.year = w[CDTIM_YEAR_LSB +: CDTIM_YEAR_W];
		d.mon = w[CDTIM_MON_LSB +: CDTIM_MON_W];
		d.day = w[CDTIM_DAY_LSB +: CDTIM_DAY_W];
		return d;
	endfunction : cdtim_unpack

	function automatic logic [CDTIM_DATA_W-1:0] cdtim_pack(input cdtim_date_s d);
		logic [CDTIM_DATA_W-1:0] w;
		w = CDTIM_ZERO;
		w[CDTIM_DC_YEAR] = d.dc_year;
		w[CDTIM_DC_MON] = d.dc_mon;
		w[CDTIM_DC_DAY] = d.dc_day;
		w[CDTIM_YEAR_LSB +: CDTIM_YEAR_W] = d.year;
		w[CDTIM_MON_LSB +: CDTIM_MON_W] = d.mon;
		w[CDTIM_DAY_LSB +: CDTIM_DAY_W] = d.day;
		return w;
	endfunction : cdtim_pack

	// a date outside 2000..2099, a month outside 1..12 or a day outside 1..31 is refused unless that field is don't-care
	function automatic logic cdtim_valid(input cdtim_date_s d);
		logic ok;
		ok = 1'b1;
		if (!d.dc_year && d.year > CDTIM_YEAR_MAX) begin
			ok = 1'b0;
		end
		if (!d.dc_mon && (d.mon < CDTIM_MON_MIN || d.mon > CDTIM_MON_MAX)) begin
			ok = 1'b0;
		end
		if (!d.dc_day && (d.day < CDTIM_DAY_MIN || d.day > CDTIM_DAY_MAX)) begin
			ok = 1'b0;
		end
		return ok;
	endfunction : cdtim_valid

	// don't-care fields take the current value so they always match
	function automatic logic [CDTIM_KEY_W-1:0] cdtim_key(input cdtim_date_s d,
		input logic [CDTIM_KEY_W-1:0] cur, input logic force_mon);
		logic [CDTIM_KEY_W-1:0] k;
		k = {d.year, d.mon, d.day};
		if (d.dc_year) begin
			k[CDTIM_KEY_W-1 -: CDTIM_YEAR_W] = cur[CDTIM_KEY_W-1 -: CDTIM_YEAR_W];
		end
		if (d.dc_mon || force_mon) begin
			k[CDTIM_DAY_W +: CDTIM_MON_W] = cur[CDTIM_DAY_W +: CDTIM_MON_W];
		end
		if (d.dc_day) begin
			k[CDTIM_DAY_W-1:0] = cur[CDTIM_DAY_W-1:0];
		end
		return k;
	endfunction : cdtim_key

	logic [CDTIM_KEY_W-1:0] cur_key;
	logic [CDTIM_KEY_W-1:0] on_key;
	logic [CDTIM_KEY_W-1:0] off_key;
	logic [CDTIM_YEAR_W-1:0] cur_y;
	logic [CDTIM_YEAR_W-1:0] on_y;
	logic [CDTIM_YEAR_W-1:0] off_y;
	logic [CDTIM_MON_W+CDTIM_DAY_W-1:0] cur_md;
	logic [CDTIM_MON_W+CDTIM_DAY_W-1:0] on_md;
	logic [CDTIM_MON_W+CDTIM_DAY_W-1:0] off_md;
	logic repeating;
	logic years_ok;
	logic active_c;
	logic match_c;
	logic day_new;
	logic fire;
	logic wr_on_ok;
	logic wr_off_ok;
	logic wr_date_bad;
	logic cfg_wr;
	cdtim_date_s wr_date;

	always_comb begin
		repeating = st_reg.yearly | st_reg.monthly;
		// the date is used only once two synchronised samples agree
		cur_key = st_reg.cur_date;
		on_key = cdtim_key(st_reg.on_date, cur_key, st_reg.monthly);
		off_key = cdtim_key(st_reg.off_date, cur_key, st_reg.monthly);
		cur_y = cur_key[CDTIM_KEY_W-1 -: CDTIM_YEAR_W];
		on_y = on_key[CDTIM_KEY_W-1 -: CDTIM_YEAR_W];
		off_y = off_key[CDTIM_KEY_W-1 -: CDTIM_YEAR_W];
		cur_md = cur_key[CDTIM_MON_W+CDTIM_DAY_W-1:0];
		on_md = on_key[CDTIM_MON_W+CDTIM_DAY_W-1:0];
		off_md = off_key[CDTIM_MON_W+CDTIM_DAY_W-1:0];
		years_ok = cur_y >= on_y && cur_y <= off_y;
		if (!repeating) begin
			active_c = cur_key >= on_key && cur_key < off_key;
			match_c = cur_key == on_key;
		end else if (on_md <= off_md) begin
			// month field is forced equal in monthly mode: compares days only
			active_c = years_ok && cur_md >= on_md && cur_md < off_md;
			match_c = years_ok && cur_md == on_md;
		end else begin
			// period runs across the year end; last start is in the year before off
			active_c = (cur_md >= on_md && cur_y >= on_y && cur_y < off_y)
				|| (cur_md < off_md && cur_y > on_y && cur_y <= off_y);
			match_c = cur_md == on_md && cur_y >= on_y && cur_y < off_y;
		end
		day_new = cur_key != st_reg.last_eval;
		fire = match_c && cur_key != st_reg.last_pulse;
		wr_date = cdtim_unpack(reg_wdata);
		wr_on_ok = reg_wr && reg_addr == CDTIM_ON_ADDR && cdtim_valid(wr_date);
		wr_off_ok = reg_wr && reg_addr == CDTIM_OFF_ADDR && cdtim_valid(wr_date);
		wr_date_bad = reg_wr && (reg_addr == CDTIM_ON_ADDR || reg_addr == CDTIM_OFF_ADDR)
			&& !cdtim_valid(wr_date);
		cfg_wr = (reg_wr && reg_addr == CDTIM_CTRL_ADDR) || wr_on_ok || wr_off_ok;
	end

	always_comb begin
		st_next = st_reg;
		st_next.sync1 = {rtc_year, rtc_month, rtc_day};
		st_next.sync2 = st_reg.sync1;
		st_next.sync3 = st_reg.sync2;
		// pins roll field by field; a half-rolled date could match falsely
		if (st_reg.sync2 == st_reg.sync3) begin
			st_next.cur_date = st_reg.sync2;
		end

		// scan-cycle evaluation
		if (scan_pulse) begin
			unique case (st_reg.fsm)
				CDTIM_IDLE: begin
					st_next.out = 1'b0;
				end
				CDTIM_RUN: begin
					if (st_reg.pulse) begin
						st_next.out = fire;
						if (fire) begin
							st_next.last_pulse = cur_key;
						end
						if (fire && !repeating) begin
							st_next.fsm = CDTIM_DONE;
						end
					end else if (day_new || st_reg.cfg_new) begin
						// the date only moves at midnight, so a new date is the 00:00 edge; a config write re-evaluates at the next scan
						st_next.out = active_c;
						st_next.last_eval = cur_key;
						st_next.cfg_new = 1'b0;
					end
				end
				CDTIM_DONE: begin
					st_next.out = 1'b0;
				end
			endcase
		end

		// control writes and accepted on/off date writes restart the schedule
		if (reg_wr && reg_addr == CDTIM_CTRL_ADDR) begin
			st_next.en = reg_wdata[CDTIM_CTRL_EN];
			st_next.yearly = reg_wdata[CDTIM_CTRL_YEARLY];
			st_next.monthly = reg_wdata[CDTIM_CTRL_MONTHLY];
			st_next.pulse = reg_wdata[CDTIM_CTRL_PULSE];
		end
		if (wr_on_ok) begin
			st_next.on_date = wr_date;
		end
		if (wr_off_ok) begin
			st_next.off_date = wr_date;
		end
		if (cfg_wr) begin
			st_next.cfg_new = 1'b1;
			st_next.last_pulse = CDTIM_NO_DATE;
			st_next.out = 1'b0;
			st_next.fsm = st_next.en ? CDTIM_RUN : CDTIM_IDLE;
		end
		// write-one clears the error; a new error in the same cycle wins
		if (reg_wr && reg_addr == CDTIM_STAT_ADDR && reg_wdata[CDTIM_STAT_ERR]) begin
			st_next.cfg_err = 1'b0;
		end
		if (wr_date_bad) begin
			st_next.cfg_err = 1'b1;
		end

		st_next.rdata = CDTIM_ZERO;
		if (reg_rd) begin
			unique case (reg_addr)
				CDTIM_CTRL_ADDR: begin
					st_next.rdata[CDTIM_CTRL_EN] = st_reg.en;
					st_next.rdata[CDTIM_CTRL_YEARLY] = st_reg.yearly;
					st_next.rdata[CDTIM_CTRL_MONTHLY] = st_reg.monthly;
					st_next.rdata[CDTIM_CTRL_PULSE] = st_reg.pulse;
				end
				CDTIM_ON_ADDR: begin
					st_next.rdata = cdtim_pack(st_reg.on_date);
				end
				CDTIM_OFF_ADDR: begin
					st_next.rdata = cdtim_pack(st_reg.off_date);
				end
				CDTIM_STAT_ADDR: begin
					st_next.rdata[CDTIM_STAT_OUT] = st_reg.out;
					st_next.rdata[CDTIM_STAT_RUN] = st_reg.fsm == CDTIM_RUN;
					st_next.rdata[CDTIM_STAT_DONE] = st_reg.fsm == CDTIM_DONE;
					st_next.rdata[CDTIM_STAT_ERR] = st_reg.cfg_err;
				end
				CDTIM_NOW_ADDR: begin
					st_next.rdata[CDTIM_YEAR_LSB +: CDTIM_YEAR_W] = cur_y;
					st_next.rdata[CDTIM_MON_LSB +: CDTIM_MON_W] = cur_key[CDTIM_DAY_W +: CDTIM_MON_W];
					st_next.rdata[CDTIM_DAY_LSB +: CDTIM_DAY_W] = cur_key[CDTIM_DAY_W-1:0];
				end
				default: begin
					st_next.rdata = CDTIM_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_reg <= '0;
			st_reg.fsm <= CDTIM_IDLE;
			st_reg.last_eval <= CDTIM_NO_DATE;
			st_reg.last_pulse <= CDTIM_NO_DATE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign timer_out = st_reg.out;
	assign reg_rdata = st_reg.rdata;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_range;
		reg_wr && reg_addr == CDTIM_ON_ADDR && !reg_wdata[CDTIM_DC_YEAR]
			&& reg_wdata[CDTIM_YEAR_LSB +: CDTIM_YEAR_W] > CDTIM_YEAR_MAX
			|=> $stable(st_reg.on_date) && st_reg.cfg_err;
	endproperty
	a_range: assert property (p_range) else $error("out-of-range date stored");

	property p_midnight;
		$rose(timer_out) && !st_reg.pulse |-> $past(day_new || st_reg.cfg_new);
	endproperty
	a_midnight: assert property (p_midnight) else $error("output rose mid-day");

	property p_fields;
		wr_on_ok |=> st_reg.on_date.year == $past(reg_wdata[CDTIM_YEAR_LSB +: CDTIM_YEAR_W])
			&& st_reg.on_date.mon == $past(reg_wdata[CDTIM_MON_LSB +: CDTIM_MON_W])
			&& st_reg.on_date.day == $past(reg_wdata[CDTIM_DAY_LSB +: CDTIM_DAY_W]);
	endproperty
	a_fields: assert property (p_fields) else $error("date fields misplaced");

	property p_level;
		scan_pulse && !reg_wr && st_reg.fsm == CDTIM_RUN && !st_reg.pulse
			&& (day_new || st_reg.cfg_new) |=> timer_out == $past(active_c);
	endproperty
	a_level: assert property (p_level) else $error("output not following schedule");

	property p_scan_only;
		!scan_pulse && !reg_wr |=> $stable(timer_out);
	endproperty
	a_scan_only: assert property (p_scan_only) else $error("output moved off scan");

	property p_pulse_one;
		scan_pulse && !reg_wr && st_reg.pulse && timer_out && cur_key == st_reg.last_pulse
			|=> !timer_out;
	endproperty
	a_pulse_one: assert property (p_pulse_one) else $error("pulse longer than one scan");

	property p_single_done;
		st_reg.fsm == CDTIM_DONE && !cfg_wr
			|=> st_reg.fsm == CDTIM_DONE && !($past(scan_pulse) && timer_out);
	endproperty
	a_single_done: assert property (p_single_done) else $error("single pulse re-armed");

	property p_after_last;
		scan_pulse && !reg_wr && repeating && st_reg.fsm == CDTIM_RUN && cur_y > off_y
			&& (day_new || st_reg.cfg_new || st_reg.pulse) |=> !timer_out;
	endproperty
	a_after_last: assert property (p_after_last) else $error("on after final year");

	property p_monthly_before;
		scan_pulse && !reg_wr && st_reg.monthly && !st_reg.pulse && st_reg.fsm == CDTIM_RUN
			&& on_md <= off_md && (cur_md < on_md || cur_md >= off_md)
			&& (day_new || st_reg.cfg_new) |=> !timer_out;
	endproperty
	a_monthly_before: assert property (p_monthly_before) else $error("monthly on outside window");

	c_yearly_on: cover property (st_reg.yearly && !st_reg.monthly && $rose(timer_out));
	c_monthly_on: cover property (st_reg.monthly && $rose(timer_out));
	c_single_pulse: cover property (st_reg.fsm == CDTIM_RUN ##1 st_reg.fsm == CDTIM_DONE);
	c_wrap_off: cover property (repeating && on_md > off_md && $fell(timer_out));
endmodule : cdtim_timer

// ==== tb/cdtim_rtc_model.sv ====
`timescale 1ns/1ps
module cdtim_rtc_model
	import cdtim_pkg::*;
(
	output logic [CDTIM_YEAR_W-1:0] rtc_year,
	output logic [CDTIM_MON_W-1:0] rtc_month,
	output logic [CDTIM_DAY_W-1:0] rtc_day
);
	initial begin
		rtc_year = 7'h00;
		rtc_month = 4'h1;
		rtc_day = 5'h01;
	end

	// no hour pins: a step of the date is the midnight tick, so level switching can only follow it or a config write
	task automatic set_date(input int y, input int m, input int d);
		rtc_year <= 7'(y - CDTIM_YEAR_BASE);
		rtc_month <= 4'(m);
		rtc_day <= 5'(d);
	endtask : set_date
endmodule : cdtim_rtc_model

// ==== tb/cdtim_timer_tb_top.sv ====
`timescale 1ns/1ps
module cdtim_timer_tb_top
	import cdtim_pkg::*;
;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [6:0] rtc_year;
	logic [3:0] rtc_month;
	logic [4:0] rtc_day;
	logic scan_pulse = 1'b0;
	logic timer_out;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;

	always #5 sys_clk = ~sys_clk;

	cdtim_rtc_model rtc (.rtc_year(rtc_year), .rtc_month(rtc_month), .rtc_day(rtc_day));

	cdtim_timer uut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rtc_year(rtc_year), .rtc_month(rtc_month), .rtc_day(rtc_day),
		.scan_pulse(scan_pulse), .timer_out(timer_out));

	task automatic end_sim();
		$display("Checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// dc is {year, month, day}
	function automatic logic [31:0] dw(input int y, input int m, input int d, input logic [2:0] dc);
		return {5'h00, dc, 1'b0, 7'(y - CDTIM_YEAR_BASE), 4'h0, 4'(m), 3'h0, 5'(d)};
	endfunction : dw

	// all bus tasks are entered just after a rising edge and leave just after one
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
		@(posedge sys_clk);
	endtask : rd

	// new date, sync flops and agreement stage, one scan, then look at the output
	task automatic step(input int y, input int m, input int d, input logic exp);
		rtc.set_date(y, m, d);
		repeat (4) @(posedge sys_clk);
		scan_pulse <= 1'b1;
		@(posedge sys_clk);
		scan_pulse <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk({31'h0, timer_out}, {31'h0, exp});
		@(posedge sys_clk);
	endtask : step

	task automatic t_reset();
		#1;
		chk({31'h0, timer_out}, 32'h0);
		@(posedge sys_clk);
		rd(CDTIM_CTRL_ADDR, 32'h0);
		rd(CDTIM_ON_ADDR, 32'h0);
		rd(CDTIM_STAT_ADDR, 32'h0);
	endtask : t_reset

	task automatic t_regs();
		wr(CDTIM_ON_ADDR, dw(2008, 6, 1, 3'b000));
		rd(CDTIM_ON_ADDR, dw(2008, 6, 1, 3'b000));
		wr(CDTIM_ON_ADDR, dw(2008, 13, 1, 3'b000));
		wr(CDTIM_ON_ADDR, dw(2100, 6, 1, 3'b000));
		rd(CDTIM_ON_ADDR, dw(2008, 6, 1, 3'b000));
		rd(CDTIM_STAT_ADDR, 32'h8);
		wr(CDTIM_STAT_ADDR, 32'h8);
		rd(CDTIM_STAT_ADDR, 32'h0);
		wr(CDTIM_OFF_ADDR, dw(2100, 1, 1, 3'b000));
		rd(CDTIM_OFF_ADDR, 32'h0);
		rd(CDTIM_STAT_ADDR, 32'h8);
		wr(CDTIM_STAT_ADDR, 32'h8);
		rd(5'h14, 32'h0);
	endtask : t_regs

	task automatic t_plain();
		wr(CDTIM_OFF_ADDR, dw(2010, 8, 31, 3'b000));
		wr(CDTIM_CTRL_ADDR, 32'h1);
		step(2008, 5, 31, 1'b0);
		rd(CDTIM_NOW_ADDR, dw(2008, 5, 31, 3'b000));
		step(2008, 6, 1, 1'b1);
		step(2009, 12, 31, 1'b1);
		step(2010, 8, 30, 1'b1);
		step(2010, 8, 31, 1'b0);
		rd(CDTIM_STAT_ADDR, 32'h2);
	endtask : t_plain

	task automatic t_wrap();
		wr(CDTIM_ON_ADDR, dw(2008, 12, 15, 3'b000));
		wr(CDTIM_OFF_ADDR, dw(2010, 1, 7, 3'b000));
		wr(CDTIM_CTRL_ADDR, 32'h3);
		step(2008, 12, 14, 1'b0);
		step(2008, 12, 15, 1'b1);
		step(2009, 1, 6, 1'b1);
		step(2009, 1, 7, 1'b0);
		step(2009, 12, 15, 1'b1);
		step(2010, 1, 7, 1'b0);
		step(2010, 12, 15, 1'b0);
	endtask : t_wrap

	task automatic t_month();
		logic [31:0] ctl [2] = '{32'h5, 32'h7};
		foreach (ctl[i]) begin
			wr(CDTIM_ON_ADDR, dw(2008, 0, 1, 3'b010));
			wr(CDTIM_OFF_ADDR, dw(2010, 0, 5, 3'b010));
			wr(CDTIM_CTRL_ADDR, ctl[i]);
			step(2007, 5, 1, 1'b0);
			step(2008, 3, 1, 1'b1);
			step(2008, 3, 5, 1'b0);
			step(2010, 12, 4, 1'b1);
			step(2011, 1, 1, 1'b0);
		end
	endtask : t_month

	task automatic t_pulse();
		wr(CDTIM_ON_ADDR, dw(2008, 3, 15, 3'b000));
		wr(CDTIM_OFF_ADDR, dw(2000, 1, 1, 3'b111));
		wr(CDTIM_CTRL_ADDR, 32'h9);
		step(2008, 3, 15, 1'b1);
		step(2008, 3, 15, 1'b0);
		rd(CDTIM_STAT_ADDR, 32'h4);
		step(2009, 3, 15, 1'b0);
		wr(CDTIM_ON_ADDR, dw(2000, 3, 15, 3'b000));
		wr(CDTIM_OFF_ADDR, dw(2099, 1, 1, 3'b011));
		wr(CDTIM_CTRL_ADDR, 32'hb);
		step(2001, 3, 15, 1'b1);
		step(2001, 3, 16, 1'b0);
		step(2002, 3, 15, 1'b1);
		wr(CDTIM_ON_ADDR, dw(2000, 1, 15, 3'b010));
		wr(CDTIM_CTRL_ADDR, 32'hd);
		step(2003, 4, 15, 1'b1);
		step(2003, 4, 16, 1'b0);
		step(2003, 5, 15, 1'b1);
	endtask : t_pulse

	// whole run is well under a thousand cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 4000) begin
			num_errors++;
			end_sim();
		end
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_regs();
		t_plain();
		t_wrap();
		t_month();
		t_pulse();
		end_sim();
	end
endmodule : cdtim_timer_tb_top
